// ===== rtl/bus_release_defines.svh
// constants for the primary bus release controller
// assumes inclusion by the package and the controller only
`ifndef BUS_RELEASE_DEFINES_SVH
`define BUS_RELEASE_DEFINES_SVH

// bus widths
`define BR_ADDR_W 24
`define BR_DATA_W 32

// one-hot release state codes
`define BR_ST_OWN    4'h1
`define BR_ST_PARK   4'h2
`define BR_ST_REL    4'h4
`define BR_ST_LINGER 4'h8

`endif

// ===== rtl/bus_release_pkg.sv
// types for the primary bus release controller
// assumes bus_release_defines.svh is on the include path
`include "bus_release_defines.svh"

package bus_release_pkg;

  // ----------------------------------------------------------------
  // release state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OWN    = `BR_ST_OWN,
    ST_PARK   = `BR_ST_PARK,
    ST_REL    = `BR_ST_REL,
    ST_LINGER = `BR_ST_LINGER
  } rel_state_e;

  typedef logic [`BR_ADDR_W-1:0] addr_t;
  typedef logic [`BR_DATA_W-1:0] data_t;

endpackage

// ===== rtl/primary_bus_release_control.sv
// primary bus access engine with release to an outside bus master
// assumes one clock clk_sys; the phase-one clock is made here at half
// that rate; the testbench resolves the data pins from data_oe
`timescale 1ns/1ps
`include "bus_release_defines.svh"

module primary_bus_release_control (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // release handshake with the outside master
  input  wire logic                   bus_release_req_n,
  output logic                        bus_release_grant_n,
  input  wire logic                   release_inhibit_bit,
  // phase-one clock
  output logic                        phase_one_clock,
  // core side
  input  wire logic                   core_rd_req,
  input  wire logic                   core_wr_req,
  input  wire bus_release_pkg::addr_t core_addr,
  input  wire bus_release_pkg::data_t core_wdata,
  output logic                        core_ack,
  output logic                        core_stall,
  output bus_release_pkg::data_t      core_rdata,
  output logic                        release_active,
  // primary bus pins
  output logic                        access_strobe_n_o,
  output logic                        access_strobe_oe,
  output logic                        rw_o,
  output logic                        rw_oe,
  output bus_release_pkg::addr_t      addr_o,
  output logic                        addr_oe,
  output bus_release_pkg::data_t      data_o,
  output logic                        data_oe,
  input  wire bus_release_pkg::data_t data_i
);

  // ----------------------------------------------------------------
  // phase-one clock divider
  // ----------------------------------------------------------------
  logic h1_r;
  logic h1_nxt;
  logic h1_fall;
  logic h1_rise;

  always_comb begin
    h1_nxt = ~h1_r;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      h1_r <= 1'b0;
    end else begin
      h1_r <= h1_nxt;
    end
  end

  // enables mark the clk_sys edge on which phase one falls or rises
  assign h1_fall = h1_r;
  assign h1_rise = ~h1_r;
  assign phase_one_clock = h1_r;

  // ----------------------------------------------------------------
  // request synchroniser
  // ----------------------------------------------------------------
  // no reset so the request is still tracked while reset is held
  logic req_meta_r;
  logic req_sync_r;
  logic req_samp_r;
  logic req_samp_nxt;

  always_ff @(posedge clk_sys) begin
    req_meta_r <= ~bus_release_req_n;
    req_sync_r <= req_meta_r;
  end

  always_comb begin
    req_samp_nxt = req_samp_r;
    if (h1_fall) begin
      req_samp_nxt = req_sync_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_samp_r <= 1'b0;
    end else begin
      req_samp_r <= req_samp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // grant carried across reset exit
  // ----------------------------------------------------------------
  // a grant given while reset is held must not be taken back before the
  // first phase-one fall, or both masters would drive the bus
  logic keep_r;
  logic keep_nxt;

  always_comb begin
    keep_nxt = rst & req_sync_r & ~release_inhibit_bit;
  end

  always_ff @(posedge clk_sys) begin
    keep_r <= keep_nxt;
  end

  // ----------------------------------------------------------------
  // release state and access engine
  // ----------------------------------------------------------------
  bus_release_pkg::rel_state_e st_r;
  bus_release_pkg::rel_state_e st_nxt;
  logic                        busy_r;
  logic                        busy_nxt;
  logic                        wr_r;
  logic                        wr_nxt;
  logic                        from_pend_r;
  logic                        from_pend_nxt;
  logic                        pend_r;
  logic                        pend_nxt;
  bus_release_pkg::addr_t      pend_addr_r;
  bus_release_pkg::addr_t      pend_addr_nxt;
  bus_release_pkg::data_t      pend_data_r;
  bus_release_pkg::data_t      pend_data_nxt;
  bus_release_pkg::addr_t      addr_r;
  bus_release_pkg::addr_t      addr_nxt;
  bus_release_pkg::data_t      wdata_r;
  bus_release_pkg::data_t      wdata_nxt;
  bus_release_pkg::data_t      rdata_r;
  bus_release_pkg::data_t      rdata_nxt;
  logic                        ack_r;
  logic                        ack_nxt;
  logic                        doe_r;
  logic                        doe_nxt;
  logic                        want;

  // request honoured only while inhibit is clear
  assign want = req_samp_nxt & ~release_inhibit_bit;

  always_comb begin
    st_nxt        = st_r;
    busy_nxt      = busy_r;
    wr_nxt        = wr_r;
    from_pend_nxt = from_pend_r;
    pend_nxt      = pend_r;
    pend_addr_nxt = pend_addr_r;
    pend_data_nxt = pend_data_r;
    addr_nxt      = addr_r;
    wdata_nxt     = wdata_r;
    rdata_nxt     = rdata_r;
    ack_nxt       = 1'b0;
    doe_nxt       = doe_r;
    // a write taken in any state but ST_OWN waits for the bus; one slot only
    if (st_r != bus_release_pkg::ST_OWN && core_wr_req && !pend_r &&
        !ack_r) begin
      pend_nxt      = 1'b1;
      pend_addr_nxt = core_addr;
      pend_data_nxt = core_wdata;
      ack_nxt       = 1'b1;
    end
    if (h1_fall) begin
      case (st_r)
        bus_release_pkg::ST_OWN: begin
          if (busy_r) begin
            busy_nxt = 1'b0;
            if (!wr_r) begin
              rdata_nxt = data_i;
            end
            if (from_pend_r) begin
              pend_nxt = 1'b0;
            end else begin
              ack_nxt = 1'b1;
            end
          end else if (want) begin
            st_nxt = bus_release_pkg::ST_PARK;
          end else if (pend_r) begin
            busy_nxt      = 1'b1;
            wr_nxt        = 1'b1;
            from_pend_nxt = 1'b1;
            addr_nxt      = pend_addr_r;
            wdata_nxt     = pend_data_r;
          end else if ((core_rd_req || core_wr_req) && !ack_r) begin
            busy_nxt      = 1'b1;
            wr_nxt        = core_wr_req & ~core_rd_req;
            from_pend_nxt = 1'b0;
            addr_nxt      = core_addr;
            wdata_nxt     = core_wdata;
          end
        end
        bus_release_pkg::ST_PARK: begin
          if (want) begin
            st_nxt = bus_release_pkg::ST_REL;
          end else begin
            st_nxt = bus_release_pkg::ST_OWN;
          end
        end
        bus_release_pkg::ST_REL: begin
          if (release_inhibit_bit) begin
            st_nxt = bus_release_pkg::ST_OWN;
          end else if (!req_samp_nxt) begin
            st_nxt = bus_release_pkg::ST_LINGER;
          end
        end
        bus_release_pkg::ST_LINGER: begin
          if (want) begin
            st_nxt = bus_release_pkg::ST_REL;
          end else begin
            st_nxt = bus_release_pkg::ST_OWN;
          end
        end
        default: begin
          st_nxt = bus_release_pkg::ST_OWN;
        end
      endcase
    end
    // data lines follow phase-one rising edges only
    if (h1_rise) begin
      doe_nxt = (st_r == bus_release_pkg::ST_OWN) & busy_r & wr_r;
    end
    // go straight into release when it was granted during reset
    if (keep_r) begin
      st_nxt = bus_release_pkg::ST_REL;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r        <= bus_release_pkg::ST_OWN;
      busy_r      <= 1'b0;
      wr_r        <= 1'b0;
      from_pend_r <= 1'b0;
      pend_r      <= 1'b0;
      pend_addr_r <= '0;
      pend_data_r <= '0;
      addr_r      <= '0;
      wdata_r     <= '0;
      rdata_r     <= '0;
      ack_r       <= 1'b0;
      doe_r       <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      busy_r      <= busy_nxt;
      wr_r        <= wr_nxt;
      from_pend_r <= from_pend_nxt;
      pend_r      <= pend_nxt;
      pend_addr_r <= pend_addr_nxt;
      pend_data_r <= pend_data_nxt;
      addr_r      <= addr_nxt;
      wdata_r     <= wdata_nxt;
      rdata_r     <= rdata_nxt;
      ack_r       <= ack_nxt;
      doe_r       <= doe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic away;
  logic granted;

  assign away    = (st_r == bus_release_pkg::ST_REL) |
                   (st_r == bus_release_pkg::ST_LINGER) |
                   (keep_r & ~rst);
  assign granted = away & ~release_inhibit_bit;

  // while reset is held the grant follows the synchronised request
  assign bus_release_grant_n = rst ?
    ~(req_sync_r & ~release_inhibit_bit) :
    ~granted;

  assign access_strobe_n_o = ~(busy_r & ~away);
  assign access_strobe_oe  = ~away & ~rst;
  assign rw_o              = ~wr_r | ~busy_r;
  assign rw_oe             = ~away & ~rst;
  assign addr_o            = addr_r;
  assign addr_oe           = ~away & ~rst;
  assign data_o            = wdata_r;
  assign data_oe           = doe_r;

  // ----------------------------------------------------------------
  // core side
  // ----------------------------------------------------------------
  assign core_ack       = ack_r;
  assign core_rdata     = rdata_r;
  assign release_active = away;
  assign core_stall     = (core_rd_req | core_wr_req) & ~ack_r;

endmodule

// ===== verif/bus_master_model.sv
// model of the outside master asking for the primary bus
// assumes the bench calls grab and drop from one process
`timescale 1ns/1ps
module bus_master_model (
  // clock and release handshake
  input  wire logic clk_sys,
  input  wire logic bus_release_grant_n,
  output logic      bus_release_req_n
);
  initial bus_release_req_n = 1'b1;
  // ask for the bus; got says whether the grant came within tmo cycles
  task automatic grab(input int tmo, output bit got);
    got = 1'b0;
    @(negedge clk_sys);
    bus_release_req_n = 1'b0;
    for (int i = 0; i < tmo && !got; i++) begin
      @(negedge clk_sys);
      got = (bus_release_grant_n === 1'b0);
    end
  endtask
  // withdraw, then wait until the grant is gone
  task automatic drop(output bit gone);
    gone = 1'b0;
    @(negedge clk_sys);
    bus_release_req_n = 1'b1;
    for (int i = 0; i < 20 && !gone; i++) begin
      @(negedge clk_sys);
      gone = (bus_release_grant_n === 1'b1);
    end
  endtask
endmodule

// ===== verif/primary_bus_release_control_checker.sv
// assertions on the primary bus release controller ports
// assumes it is bound onto every instance of the controller
`timescale 1ns/1ps
module primary_bus_release_control_checker (
  // clock, reset and release handshake
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic bus_release_req_n,
  input wire logic bus_release_grant_n,
  input wire logic release_inhibit_bit,
  input wire logic phase_one_clock,
  // release status, strobe and bus pin enables
  input wire logic release_active,
  input wire logic access_strobe_n_o,
  input wire logic access_strobe_oe,
  input wire logic rw_oe,
  input wire logic addr_oe,
  input wire logic data_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_asked;
    (!bus_release_req_n && !release_inhibit_bit)[*8];
  endsequence
  sequence s_left;
    (bus_release_req_n && !release_inhibit_bit)[*8];
  endsequence
  property p_grant_fall;
    $changed(bus_release_grant_n) && !$past(rst) && !release_inhibit_bit
      && !$past(release_inhibit_bit) |-> $past(phase_one_clock);
  endproperty
  a_grant_fall: assert property (p_grant_fall)
    else $error("grant moved off a fall");
  property p_req_grant;
    s_asked |-> ##[0:8] (!bus_release_grant_n || bus_release_req_n
      || release_inhibit_bit);
  endproperty
  a_req_grant: assert property (p_req_grant)
    else $error("grant late");
  property p_grant_drop; s_left |-> bus_release_grant_n; endproperty
  a_grant_drop: assert property (p_grant_drop)
    else $error("grant kept");
  property p_inh; release_inhibit_bit |-> bus_release_grant_n; endproperty
  a_inh: assert property (p_inh) else $error("inhibit grant");
  property p_inh_end; release_inhibit_bit[*3] |-> !release_active; endproperty
  a_inh_end: assert property (p_inh_end)
    else $error("release kept");
  property p_float;
    release_active |-> !(access_strobe_oe || rw_oe || addr_oe || data_oe);
  endproperty
  a_float: assert property (p_float) else $error("pins driven");
  property p_strobe_first;
    $fell(access_strobe_oe) |-> $past(access_strobe_n_o)
      && $past(phase_one_clock);
  endproperty
  a_strobe_first: assert property (p_strobe_first)
    else $error("strobe float");
  property p_back;
    $fell(release_active) |-> access_strobe_oe && rw_oe && addr_oe
      && $past(phase_one_clock);
  endproperty
  a_back: assert property (p_back) else $error("pins not back");
  property p_data_rise;
    $changed(data_oe) |-> !$past(phase_one_clock);
  endproperty
  a_data_rise: assert property (p_data_rise)
    else $error("data enable moved off a rise");
endmodule
bind primary_bus_release_control primary_bus_release_control_checker
  i_chk (
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .bus_release_req_n   (bus_release_req_n),
    .bus_release_grant_n (bus_release_grant_n),
    .release_inhibit_bit (release_inhibit_bit),
    .phase_one_clock     (phase_one_clock),
    .release_active      (release_active),
    .access_strobe_n_o   (access_strobe_n_o),
    .access_strobe_oe    (access_strobe_oe),
    .rw_oe               (rw_oe),
    .addr_oe             (addr_oe),
    .data_oe             (data_oe)
  );

// ===== verif/primary_bus_release_control_tb.sv
// self-checking bench for the primary bus release controller
// assumes the checker binds itself and the master model sits beside
`timescale 1ns/1ps
module primary_bus_release_control_tb;
  logic                   clk_sys = 1'b0;
  logic                   rst = 1'b1;
  logic                   release_inhibit_bit = 1'b0;
  logic                   core_rd_req = 1'b0;
  logic                   core_wr_req = 1'b0;
  bus_release_pkg::addr_t core_addr = '0;
  bus_release_pkg::data_t core_wdata = '0;
  bus_release_pkg::addr_t addr_o;
  bus_release_pkg::data_t data_i, data_o, core_rdata;
  logic bus_release_req_n, bus_release_grant_n, phase_one_clock, core_ack;
  logic core_stall, release_active, access_strobe_n_o, access_strobe_oe;
  logic rw_o, rw_oe, addr_oe, data_oe;
  int   mismatches = 0;
  int   tests_run = 0;
  int   cyc = 0;
  int   strobes = 0;
  bit   ok;
  always #50 clk_sys = ~clk_sys;
  primary_bus_release_control i_dut (
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .bus_release_req_n   (bus_release_req_n),
    .bus_release_grant_n (bus_release_grant_n),
    .release_inhibit_bit (release_inhibit_bit),
    .phase_one_clock     (phase_one_clock),
    .core_rd_req         (core_rd_req),
    .core_wr_req         (core_wr_req),
    .core_addr           (core_addr),
    .core_wdata          (core_wdata),
    .core_ack            (core_ack),
    .core_stall          (core_stall),
    .core_rdata          (core_rdata),
    .release_active      (release_active),
    .access_strobe_n_o   (access_strobe_n_o),
    .access_strobe_oe    (access_strobe_oe),
    .rw_o                (rw_o),
    .rw_oe               (rw_oe),
    .addr_o              (addr_o),
    .addr_oe             (addr_oe),
    .data_o              (data_o),
    .data_oe             (data_oe),
    .data_i              (data_i)
  );
  bus_master_model i_master (
    .clk_sys             (clk_sys),
    .bus_release_grant_n (bus_release_grant_n),
    .bus_release_req_n   (bus_release_req_n)
  );
  // memory word is a fixed scramble of the address
  function automatic bus_release_pkg::data_t mem_word(
    input bus_release_pkg::addr_t a);
    return {a[7:0], a} ^ 32'h5a5ac3c3;
  endfunction
  assign data_i = data_oe ? data_o : mem_word(addr_o);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one core access; the request is dropped only once answered
  task automatic access(input bit rd, input int tmo, output bit acked);
    acked = 1'b0;
    @(negedge clk_sys);
    core_rd_req = rd;
    core_wr_req = !rd;
    for (int i = 0; i < tmo && !acked; i++) begin
      @(negedge clk_sys);
      if (access_strobe_n_o === 1'b0) begin
        strobes++;
        chk({rw_o, addr_oe, addr_o}, {rd, 1'b1, core_addr});
      end
      if (data_oe === 1'b1) chk(data_o, core_wdata);
      acked = (core_ack === 1'b1);
    end
    if (acked) begin
      core_rd_req = 1'b0;
      core_wr_req = 1'b0;
      if (rd) chk(core_rdata, mem_word(core_addr));
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h47a313f5));
    // request held through reset
    i_master.grab(0, ok);
    repeat (3) @(negedge clk_sys);
    chk(bus_release_grant_n, 1'b0);
    @(negedge clk_sys);
    rst = 1'b0;
    // the grant given in reset stands and the bus stays floated
    @(negedge clk_sys);
    chk({bus_release_grant_n, addr_oe, release_active}, 3'b001);
    i_master.grab(20, ok);
    chk(ok, 1'b1);
    i_master.drop(ok);
    chk(ok, 1'b1);
    $display("test 1 done");
    // accesses, lowest and highest address first
    for (int n = 0; n < 8; n++) begin
      core_addr = (n == 0) ? '0 : (n == 1) ? '1 : 24'($urandom);
      core_wdata = $urandom;
      access(n[0], 12, ok);
      chk(ok, 1'b1);
    end
    // every access holds the strobe low across two bench samples
    chk(strobes, 16);
    $display("test 2 done");
    // released bus: parked write, then stall until return
    for (int r = 0; r < 2; r++) begin
      core_addr = 24'($urandom);
      i_master.grab(20, ok);
      chk({ok, addr_oe, rw_oe, access_strobe_oe, data_oe}, 5'h10);
      if (r == 0) begin
        access(1'b0, 6, ok);
        chk(ok, 1'b1);
      end
      access(r[0], 8, ok);
      chk({ok, core_stall}, 2'b01);
      i_master.drop(ok);
      access(r[0], 30, ok);
      chk(ok, 1'b1);
    end
    $display("test 3 done");
    // inhibit ends the release and keeps the bus
    i_master.grab(20, ok);
    chk(ok, 1'b1);
    release_inhibit_bit = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({bus_release_grant_n, release_active}, 2'b10);
    access(1'b1, 12, ok);
    chk({ok, bus_release_grant_n}, 2'b11);
    release_inhibit_bit = 1'b0;
    i_master.drop(ok);
    $display("test 4 done");
    wrap_up();
  end
endmodule
